//--- core/scc_pkg.sv
// package: register map, field layout, reset values and carrier types of the capture/compare timer
package scc_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] SCC_ADDR_STATUS = 8'h20;
  localparam logic [7:0] SCC_ADDR_COUNT_HI = 8'h22;
  localparam logic [7:0] SCC_ADDR_COUNT_LO = 8'h23;
  localparam logic [7:0] SCC_ADDR_LIMIT_HI = 8'h24;
  localparam logic [7:0] SCC_ADDR_LIMIT_LO = 8'h25;
  localparam logic [7:0] SCC_ADDR_CH_BASE = 8'h26;
  localparam logic [7:0] SCC_CH_STRIDE = 8'h03;
  localparam logic [7:0] SCC_CH_OFS_HI = 8'h01;
  localparam logic [7:0] SCC_CH_OFS_LO = 8'h02;

  // ***************************************************************
  // values after reset and codes
  // ***************************************************************
  localparam logic [15:0] SCC_LIMIT_RESET = 16'hffff;
  localparam logic [15:0] SCC_COUNT_RESET = 16'h0000;
  localparam logic [5:0] SCC_PRESCALE_RESET = 6'h00;
  localparam logic [2:0] SCC_PRESCALE_EXT = 3'h7;
  localparam logic [1:0] SCC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] SCC_ACT_CLEAR = 2'h2;
  localparam logic [1:0] SCC_ACT_SET = 2'h3;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic ovf_flag;
    logic ovf_irq_en;
    logic counter_halt_bit;
    logic counter_reset_bit;
    logic unused_zero;
    logic [2:0] prescale_select;
  } scc_status_t;

  localparam scc_status_t SCC_STATUS_RESET = 8'h20;

  typedef struct packed {
    logic channel_event_flag;
    logic irq_en;
    logic mode_select_hi;
    logic mode_select_lo;
    logic edge_select_hi;
    logic edge_select_lo;
    logic toggle_on_ovf;
    logic max_duty;
  } scc_chan_ctl_t;

  localparam scc_chan_ctl_t SCC_CHAN_CTL_RESET = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scc_bus_req_t;

endpackage

//--- core/scc_timer_module.sv
// six-channel capture/compare timer with a shared 16-bit up-counter
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
// Behaviour
// (R1) 16-bit up-counter runs free or modulo; time base for every channel.
// (R2) the counter limit registers hold the modulo value of the counter.
// (R3) reading the counter never disturbs counting.
// (R4) six channels, each input capture or output compare.
// (R5) three-bit prescale select: seven bus-clock divisions or the external clock pin.
// (R6) active edge on pin copies counter into channel value; edge bits pick polarity.
// (R7) capture happens on every qualifying edge whatever the flag state.
// (R8) flag with enabled interrupt raises the interrupt request; flag always pollable.
// (R9) captured value lands in the channel registers two clocks after the edge.
// (R10) a later capture overwrites the earlier captured value.
// (R11) reset leaves channel value registers untouched.
// (R12) compare match sets, clears or toggles the pin and sets the flag.
// (R13) unbuffered compare value is replaced at once by a write.
// (R14) software picks safe moments to change unbuffered compare values.
// (R15) buffer select on channel 0 links channels 0 and 1 onto pin 0.
// (R16) even set governs first; last-written set takes over at each overflow.
// (R17) linked: even control governs, odd control unused, odd pin released.
// (R18) pairs 2/3 and 4/5 link the same way through their even channel.
// (R19) software writes only the inactive set of a linked pair.
// (R20) software counts overflows to extend measurements.
// (R21) mode 0:1 unbuffered, 1:0 buffered; edge 1:0 clears, 1:1 sets.
// (R22) status register has a stop bit and a counter-and-prescaler reset bit.
// (R23) at the limit the counter wraps to zero next tick and sets overflow flag.
module scc_timer_module
  import scc_pkg::*;
#(
  parameter int CHANNELS = 6,
  parameter int PRESCALE_BITS = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire scc_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic external_timer_clock_pin,
  input wire logic [CHANNELS-1:0] channel_pin_in,
  output logic [CHANNELS-1:0] channel_pin_out,
  output logic [CHANNELS-1:0] channel_pin_oe_n,
  output logic irq
);

  localparam int PAIRS = CHANNELS / 2;
  localparam int NIN = CHANNELS + 1;

  // ***************************************************************
  // state
  // ***************************************************************
  scc_status_t status;
  logic [15:0] count;
  logic [15:0] limit;
  logic [PRESCALE_BITS-1:0] prescale;
  logic cnt_moved;
  scc_chan_ctl_t ctl [CHANNELS];
  logic [15:0] chan_val [CHANNELS];
  logic [CHANNELS-1:0] cap_pend;
  logic [15:0] cap_val [CHANNELS];
  logic [CHANNELS-1:0] pin_lvl;
  logic [PAIRS-1:0] last_odd;
  logic [PAIRS-1:0] act_odd;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] sync3;
  logic [NIN-1:0] in_lvl;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  wire [NIN-1:0] pins_raw = {external_timer_clock_pin, channel_pin_in};
  // change only once the two late stages agree, filtering one-clock glitches
  wire [NIN-1:0] in_change = ~(sync2 ^ sync3) & (sync3 ^ in_lvl);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      in_lvl <= '0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      in_lvl <= in_lvl ^ in_change;
    end
  end

  // ***************************************************************
  // bus decode
  // ***************************************************************
  wire wr = bus_req.wr;
  wire [7:0] addr = bus_req.addr;
  wire [7:0] wdata = bus_req.wdata;
  wire sel_status = addr == SCC_ADDR_STATUS;
  wire sel_cnt_hi = addr == SCC_ADDR_COUNT_HI;
  wire sel_cnt_lo = addr == SCC_ADDR_COUNT_LO;
  wire sel_lim_hi = addr == SCC_ADDR_LIMIT_HI;
  wire sel_lim_lo = addr == SCC_ADDR_LIMIT_LO;
  wire wr_status = wr & sel_status;
  wire scc_status_t wstat = wdata;
  wire clr_cmd = wr_status & wstat.counter_reset_bit; // [R22]
  // flags clear on a written zero; a written one leaves them alone
  wire ovf_clr = wr_status & ~wstat.ovf_flag;

  // ***************************************************************
  // prescaler and counter
  // ***************************************************************
  wire [PRESCALE_BITS:0] pre_full = ((PRESCALE_BITS+1)'(1) << status.prescale_select) - (PRESCALE_BITS+1)'(1);
  wire [PRESCALE_BITS-1:0] pre_mask = pre_full[PRESCALE_BITS-1:0];
  // select n ticks every 2**n bus clocks, select 7 follows the pin
  wire pre_tick = &(prescale | ~pre_mask); // [R5]
  wire ext_rise = in_change[CHANNELS] & sync3[CHANNELS];
  wire tick = (status.prescale_select == SCC_PRESCALE_EXT) ? ext_rise : pre_tick; // [R5]
  wire step = tick & ~status.counter_halt_bit & ~clr_cmd; // [R22]
  wire at_limit = count == limit; // [R2]
  wire ovf_evt = step & at_limit; // [R23]

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prescale <= SCC_PRESCALE_RESET;
      count <= SCC_COUNT_RESET;
      cnt_moved <= 1'b0;
    end else begin
      prescale <= clr_cmd ? SCC_PRESCALE_RESET : prescale + 1'b1; // [R22]
      cnt_moved <= step;
      if (clr_cmd) begin
        count <= SCC_COUNT_RESET; // [R22]
      end else if (step) begin
        count <= at_limit ? SCC_COUNT_RESET : count + 16'h0001; // [R1] [R23]
      end
    end
  end

  // ***************************************************************
  // status and limit registers
  // ***************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status <= SCC_STATUS_RESET;
      limit <= SCC_LIMIT_RESET;
    end else begin
      if (wr_status) begin
        status.ovf_irq_en <= wstat.ovf_irq_en;
        status.counter_halt_bit <= wstat.counter_halt_bit; // [R22]
        status.prescale_select <= wstat.prescale_select; // [R5]
      end
      // a new overflow beats a clear in the same cycle
      status.ovf_flag <= ovf_evt | (status.ovf_flag & ~ovf_clr); // [R23]
      if (wr & sel_lim_hi) begin
        limit[15:8] <= wdata; // [R2]
      end
      if (wr & sel_lim_lo) begin
        limit[7:0] <= wdata; // [R2]
      end
    end
  end

  // ***************************************************************
  // per-channel decode and datapath
  // ***************************************************************
  logic [CHANNELS-1:0] sel_ctl;
  logic [CHANNELS-1:0] sel_hi;
  logic [CHANNELS-1:0] sel_lo;
  logic [CHANNELS-1:0] buf_on;
  logic [CHANNELS-1:0] shadowed;
  logic [CHANNELS-1:0] oc_mode;
  logic [CHANNELS-1:0] ic_mode;
  logic [CHANNELS-1:0] match;
  logic [CHANNELS-1:0] cap_hit;
  logic [CHANNELS-1:0] drive;
  logic [CHANNELS-1:0] next_pin;
  logic [CHANNELS-1:0] ev;
  logic [CHANNELS-1:0] flag_clr;
  logic [15:0] cmp [CHANNELS];
  logic [7:0] ch_rd [CHANNELS];
  scc_chan_ctl_t wctl;

  assign wctl = wdata;

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      localparam logic [7:0] BASE = 8'(SCC_ADDR_CH_BASE + SCC_CH_STRIDE * gi);
      wire [1:0] edges = {ctl[gi].edge_select_hi, ctl[gi].edge_select_lo};
      assign sel_ctl[gi] = addr == BASE;
      assign sel_hi[gi] = addr == 8'(BASE + SCC_CH_OFS_HI);
      assign sel_lo[gi] = addr == 8'(BASE + SCC_CH_OFS_LO);
      if (gi % 2 == 0) begin : g_even
        assign buf_on[gi] = ctl[gi].mode_select_hi; // [R15] [R18]
        assign shadowed[gi] = 1'b0;
        // linked pair: the set chosen at the last overflow is compared
        assign cmp[gi] = (buf_on[gi] & act_odd[gi/2]) ? chan_val[gi+1] : chan_val[gi]; // [R16]
      end else begin : g_odd
        assign buf_on[gi] = 1'b0;
        assign shadowed[gi] = ctl[gi-1].mode_select_hi; // [R17]
        assign cmp[gi] = chan_val[gi];
      end
      assign oc_mode[gi] = ~shadowed[gi] & (buf_on[gi] | ctl[gi].mode_select_lo); // [R4] [R21]
      assign ic_mode[gi] = ~shadowed[gi] & ~buf_on[gi] & ~ctl[gi].mode_select_lo; // [R4]
      // compare is checked against the value live this cycle, so a rewrite acts at once
      assign match[gi] = oc_mode[gi] & cnt_moved & (count == cmp[gi]); // [R12] [R13]
      wire rise_seen = in_change[gi] & sync3[gi];
      wire fall_seen = in_change[gi] & ~sync3[gi];
      assign cap_hit[gi] = ic_mode[gi]
                       & ((rise_seen & ctl[gi].edge_select_lo) | (fall_seen & ctl[gi].edge_select_hi)); // [R6]
      // edge bits 00 leave the pin to port logic even in compare mode
      assign drive[gi] = oc_mode[gi] & (edges != 2'h0);
      wire act_lvl = (edges == SCC_ACT_TOGGLE) ? ~pin_lvl[gi] :
                     (edges == SCC_ACT_SET) ? 1'b1 :
                     (edges == SCC_ACT_CLEAR) ? 1'b0 : pin_lvl[gi]; // [R12] [R21]
      // a match and an overflow toggle in one cycle: the match action wins
      wire ovf_tgl = ovf_evt & oc_mode[gi] & ctl[gi].toggle_on_ovf;
      assign next_pin[gi] = match[gi] ? act_lvl : (ovf_tgl ? ~pin_lvl[gi] : pin_lvl[gi]); // [R12]
      assign ev[gi] = cap_pend[gi] | match[gi]; // [R12]
      assign flag_clr[gi] = wr & sel_ctl[gi] & ~wctl.channel_event_flag;
      // link bit reads back only where it can be set, so odd channels show 0
      wire [7:0] ctl_rd = {ctl[gi].channel_event_flag, ctl[gi].irq_en, buf_on[gi], ctl[gi][4:0]};
      assign ch_rd[gi] = ({8{sel_ctl[gi]}} & ctl_rd)
                       | ({8{sel_hi[gi]}} & chan_val[gi][15:8])
                       | ({8{sel_lo[gi]}} & chan_val[gi][7:0]);
    end
  endgenerate

  // ***************************************************************
  // channel control, capture pipeline and pin levels
  // ***************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        ctl[i] <= SCC_CHAN_CTL_RESET;
      end
      cap_pend <= '0;
      pin_lvl <= '0;
    end else begin
      cap_pend <= cap_hit; // [R9]
      pin_lvl <= next_pin; // [R12]
      for (int i = 0; i < CHANNELS; i++) begin
        if (wr & sel_ctl[i]) begin
          ctl[i][6:0] <= {wctl.irq_en, wctl.mode_select_hi & ~i[0], wctl[4:0]}; // [R17]
        end
        // capture is taken even with the flag still set; set beats clear
        ctl[i].channel_event_flag <= ev[i] | (ctl[i].channel_event_flag & ~flag_clr[i]); // [R7] [R8]
      end
    end
  end

  // counter value seen at the edge, parked one clock before it lands
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      cap_val[i] <= count; // [R9]
    end
  end

  // value registers have no reset on purpose
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (cap_pend[i]) begin
        chan_val[i] <= cap_val[i]; // [R6] [R9] [R10] [R11]
      end else begin
        if (wr & sel_hi[i]) begin
          chan_val[i][15:8] <= wdata; // [R13]
        end
        if (wr & sel_lo[i]) begin
          chan_val[i][7:0] <= wdata; // [R13]
        end
      end
    end
  end

  // ***************************************************************
  // linked-pair tracking
  // ***************************************************************
  logic [PAIRS-1:0] wr_even_set;
  logic [PAIRS-1:0] wr_odd_set;

  // any byte of a value set marks that set as last written
  generate
    for (gi = 0; gi < PAIRS; gi++) begin : g_pair
      assign wr_even_set[gi] = wr & (sel_hi[2*gi] | sel_lo[2*gi]); // [R16]
      assign wr_odd_set[gi] = wr & (sel_hi[2*gi+1] | sel_lo[2*gi+1]); // [R16]
    end
  endgenerate

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      last_odd <= '0;
      act_odd <= '0;
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        if (wr_even_set[p]) begin
          last_odd[p] <= 1'b0; // [R16]
        end else if (wr_odd_set[p]) begin
          last_odd[p] <= 1'b1; // [R16]
        end
        if (!buf_on[2*p]) begin
          act_odd[p] <= 1'b0; // [R16]
        end else if (ovf_evt) begin
          act_odd[p] <= last_odd[p]; // [R16] [R23]
        end
      end
    end
  end

  // ***************************************************************
  // read mux and outputs
  // ***************************************************************
  logic [7:0] ch_any;
  always_comb begin
    ch_any = 8'h00;
    for (int i = 0; i < CHANNELS; i++) begin
      ch_any = ch_any | ch_rd[i];
    end
  end

  // counter reads are side-effect free
  wire [7:0] next_rd = ({8{sel_status}} & {status[7:5], 5'(status.prescale_select)})
                     | ({8{sel_cnt_hi}} & count[15:8]) // [R3]
                     | ({8{sel_cnt_lo}} & count[7:0]) // [R3]
                     | ({8{sel_lim_hi}} & limit[15:8])
                     | ({8{sel_lim_lo}} & limit[7:0])
                     | ch_any;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= bus_req.rd ? next_rd : 8'h00;
    end
  end

  // released pins (inputs, odd of a linked pair) keep oe_n high
  assign channel_pin_out = pin_lvl;
  assign channel_pin_oe_n = ~drive; // [R17]

  // ***************************************************************
  // interrupt request
  // ***************************************************************
  logic [CHANNELS-1:0] ch_irq;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_irq
      assign ch_irq[gi] = ctl[gi].channel_event_flag & ctl[gi].irq_en;
    end
  endgenerate

  assign irq = (|ch_irq) | (status.ovf_flag & status.ovf_irq_en); // [R8]

endmodule // scc_timer_module

//--- tb/scc_pin_env.sv
// pin-side model: signal sources on the channel pins and the external count clock
`timescale 1ns/10ps
module scc_pin_env (
  input wire logic core_clk,
  input wire logic [5:0] channel_pin_out,
  input wire logic [5:0] channel_pin_oe_n,
  output wire logic [5:0] channel_pin_in,
  output logic external_timer_clock_pin
);
  logic [5:0] src = 6'h00;
  initial external_timer_clock_pin = 1'b0;
  // a driven pin reads back its own level, a released one the outside source
  assign channel_pin_in = (channel_pin_oe_n & src) | (~channel_pin_oe_n & channel_pin_out);

  task automatic set_pin(input int i, input logic v);
    @(posedge core_clk);
    src[i] <= v;
  endtask

  // five clocks a period so the synchroniser sees every edge; idle low between bursts
  task automatic pulse_ext(input int n);
    repeat (n) begin
      @(posedge core_clk);
      external_timer_clock_pin <= 1'b1;
      repeat (2) @(posedge core_clk);
      external_timer_clock_pin <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
endmodule // scc_pin_env

//--- tb/scc_timer_sva.sv
// port-level assertion checker for the capture/compare timer
`timescale 1ns/10ps
module scc_timer_sva
  import scc_pkg::*;
#(
  parameter int CHANNELS = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire scc_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic external_timer_clock_pin,
  input wire logic [CHANNELS-1:0] channel_pin_in,
  input wire logic [CHANNELS-1:0] channel_pin_out,
  input wire logic [CHANNELS-1:0] channel_pin_oe_n,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ***************************************************************
  // access decodes
  // ***************************************************************
  wire logic rd_status = bus_req.rd && bus_req.addr == SCC_ADDR_STATUS;
  wire logic wr_ctl0 = bus_req.wr && bus_req.addr == SCC_ADDR_CH_BASE;
  wire logic wr_ctl2 = bus_req.wr && bus_req.addr == 8'h2c;
  wire logic rd_odd_ctl = bus_req.rd && bus_req.addr inside {8'h29, 8'h2f, 8'h35};

  // ***************************************************************
  // assertions
  // ***************************************************************
  chk_read_window: assert property (rd_data != 8'h00 |-> $past(bus_req.rd))
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property (bus_req.rd && bus_req.addr == 8'h21 |=> rd_data == 8'h00)
    else $error("unmapped place read nonzero");
  chk_status_spare: assert property (rd_status |=> rd_data[4:3] == 2'b00)
    else $error("status spare bits read nonzero");
  chk_odd_link_bit: assert property (rd_odd_ctl |=> rd_data[5] == 1'b0)
    else $error("odd control link bit reads one");
  chk_halt_clear: assert property (bus_req.wr && bus_req.addr == SCC_ADDR_STATUS && bus_req.wdata[5:4] == 2'b11
    ##1 !bus_req.wr ##1 bus_req.rd && bus_req.addr == SCC_ADDR_COUNT_LO |=> rd_data == 8'h00)
    else $error("count not cleared by reset bit");
  chk_limit_echo: assert property (bus_req.wr && bus_req.addr == SCC_ADDR_LIMIT_LO
    ##2 bus_req.rd && bus_req.addr == SCC_ADDR_LIMIT_LO |=> rd_data == $past(bus_req.wdata, 3))
    else $error("limit byte not held");
  chk_capture_drive: assert property (wr_ctl0 && bus_req.wdata[5:4] == 2'b00 |=> channel_pin_oe_n[0])
    else $error("capture channel drives its pin");
  chk_compare_drive: assert property (wr_ctl2 && bus_req.wdata[5:2] == 4'b0111 |=> !channel_pin_oe_n[2])
    else $error("compare channel does not drive its pin");
  chk_linked_release: assert property (wr_ctl0 && bus_req.wdata[5] |=> channel_pin_oe_n[1])
    else $error("odd pin of linked pair still driven");

  cover property (!channel_pin_oe_n[2] && channel_pin_out[2]);
  cover property ($rose(irq));
  cover property (wr_ctl0 && bus_req.wdata[5]);
endmodule // scc_timer_sva

bind scc_timer_module scc_timer_sva #(.CHANNELS(CHANNELS)) chk_u (.core_clk(core_clk), .reset(reset),
  .bus_req(bus_req), .rd_data(rd_data), .external_timer_clock_pin(external_timer_clock_pin),
  .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
  .channel_pin_oe_n(channel_pin_oe_n), .irq(irq));

//--- tb/testbench.sv
// self-checking bench: register tasks and pin scenarios for the capture/compare timer
`timescale 1ns/10ps
module testbench;
  import scc_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  scc_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic [7:0] b;
  logic [7:0] b2;
  logic ext_pin;
  logic [5:0] pin_in;
  logic [5:0] pin_out;
  logic [5:0] pin_oe_n;
  logic irq;
  int fails = 0;
  int compares = 0;

  scc_timer_module dut_u (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .external_timer_clock_pin(ext_pin), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe_n(pin_oe_n), .irq(irq));
  scc_pin_env env_u (.core_clk(core_clk), .channel_pin_out(pin_out), .channel_pin_oe_n(pin_oe_n),
    .channel_pin_in(pin_in), .external_timer_clock_pin(ext_pin));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // ***************************************************************
  // bus and compare tasks
  // ***************************************************************
  // a gap cycle after each access keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    bus_req <= '0;
    #1 d = rd_data;
    @(posedge core_clk);
  endtask
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    rd(a, b);
    cmp($sformatf("reg %h", a), {8'h00, exp}, {8'h00, b});
  endtask
  task automatic chk16(input logic [7:0] a, input logic [15:0] exp);
    logic [7:0] h;
    rd(a, h);
    rd(a + 8'h01, b);
    cmp($sformatf("pair %h", a), exp, {h, b});
  endtask
  task automatic chk_pin(input int i, input logic e);
    repeat (4) @(posedge core_clk);
    cmp($sformatf("pin %0d", i), {15'h0000, e}, {15'h0000, pin_out[i]});
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #300000;
    fails++;
    test_done;
  end

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk_reg(SCC_ADDR_STATUS, 8'h20);
    chk16(SCC_ADDR_LIMIT_HI, 16'hffff);
    for (int i = 0; i < 6; i++) begin
      chk_reg(SCC_ADDR_CH_BASE + 8'(3 * i), 8'h00);
    end
    chk_reg(8'h21, 8'h00);
    wr(SCC_ADDR_COUNT_LO, 8'h55);
    chk16(SCC_ADDR_COUNT_HI, 16'h0000);
    // modulo 4 at full rate; a halting write with bit 7 set keeps the overflow flag
    wr(SCC_ADDR_LIMIT_HI, 8'h00);
    wr(SCC_ADDR_LIMIT_LO, 8'h03);
    chk_reg(SCC_ADDR_LIMIT_LO, 8'h03);
    wr(SCC_ADDR_STATUS, 8'h00);
    repeat (12) @(posedge core_clk);
    wr(SCC_ADDR_STATUS, 8'ha0);
    rd(SCC_ADDR_STATUS, b);
    cmp("overflow flag", 16'h0001, {15'h0000, b[7]});
    rd(SCC_ADDR_COUNT_LO, b);
    cmp("count within limit", 16'h0001, {15'h0000, b <= 8'h03});
    wr(SCC_ADDR_STATUS, 8'h30);
    chk_reg(SCC_ADDR_COUNT_LO, 8'h00);
    chk_reg(SCC_ADDR_STATUS, 8'h20);
    // every internal division over the same span
    wr(SCC_ADDR_LIMIT_HI, 8'hff);
    wr(SCC_ADDR_LIMIT_LO, 8'hff);
    for (int n = 0; n < 7; n++) begin
      wr(SCC_ADDR_STATUS, 8'h10 | 8'(n));
      repeat (126) @(posedge core_clk);
      wr(SCC_ADDR_STATUS, 8'h20 | 8'(n));
      rd(SCC_ADDR_COUNT_LO, b);
      cmp("divided count", 16'h0001, {15'h0000, b >= 8'(128 >> n) - 8'h02 && b <= 8'(128 >> n) + 8'h01});
    end
    // capture on rising edge, counting external ticks
    wr(SCC_ADDR_STATUS, 8'h17);
    wr(SCC_ADDR_CH_BASE, 8'h44);
    env_u.pulse_ext(9);
    env_u.set_pin(0, 1'b1);
    repeat (6) @(posedge core_clk);
    chk16(SCC_ADDR_CH_BASE + 8'h01, 16'h0009);
    chk_reg(SCC_ADDR_CH_BASE, 8'hc4);
    cmp("irq", 16'h0001, {15'h0000, irq});
    env_u.pulse_ext(3);
    env_u.set_pin(0, 1'b0);
    repeat (4) @(posedge core_clk);
    env_u.set_pin(0, 1'b1);
    repeat (6) @(posedge core_clk);
    chk16(SCC_ADDR_CH_BASE + 8'h01, 16'h000c);
    wr(SCC_ADDR_CH_BASE, 8'h44);
    cmp("irq", 16'h0000, {15'h0000, irq});
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk16(SCC_ADDR_CH_BASE + 8'h01, 16'h000c);
    // captures on channels 1-5 across one wrap of a modulo-4 count: falling, both or rising
    wr(SCC_ADDR_LIMIT_HI, 8'h00);
    wr(SCC_ADDR_LIMIT_LO, 8'h03);
    wr(SCC_ADDR_STATUS, 8'h17);
    for (int i = 1; i < 6; i++) begin
      wr(SCC_ADDR_CH_BASE + 8'(3 * i), {4'h0, 2'(i % 3 + 1), 2'b00});
    end
    env_u.pulse_ext(2);
    for (int i = 1; i < 6; i++) begin
      env_u.set_pin(i, 1'b1);
    end
    repeat (6) @(posedge core_clk);
    env_u.pulse_ext(3);
    for (int i = 1; i < 6; i++) begin
      env_u.set_pin(i, 1'b0);
    end
    repeat (6) @(posedge core_clk);
    chk16(8'h2a, 16'h0001);
    chk16(8'h2d, 16'h0001);
    chk16(8'h30, 16'h0002);
    chk16(8'h33, 16'h0001);
    chk16(8'h36, 16'h0001);
    rd(SCC_ADDR_STATUS, b2);
    rd(8'h31, b);
    cmp("span over wrap", 16'h0003, 16'({b2[7], 2'b00}) + 16'h0001 - 16'(b));
    // compare on channel 2: set, clear, toggle, then a value moved behind the count
    wr(8'h2d, 8'h00);
    wr(8'h2e, 8'h05);
    wr(SCC_ADDR_LIMIT_HI, 8'h00);
    wr(SCC_ADDR_LIMIT_LO, 8'h07);
    wr(8'h2c, 8'h5c);
    cmp("drive enable", 16'h0000, {15'h0000, pin_oe_n[2]});
    wr(SCC_ADDR_STATUS, 8'h17);
    env_u.pulse_ext(4);
    chk_pin(2, 1'b0);
    env_u.pulse_ext(1);
    chk_pin(2, 1'b1);
    chk_reg(8'h2c, 8'hdc);
    wr(8'h2c, 8'h58);
    env_u.pulse_ext(8);
    chk_pin(2, 1'b0);
    wr(8'h2c, 8'h54);
    env_u.pulse_ext(8);
    chk_pin(2, 1'b1);
    wr(8'h2e, 8'h03);
    env_u.pulse_ext(2);
    chk_pin(2, 1'b1);
    env_u.pulse_ext(4);
    chk_pin(2, 1'b0);
    // linked pairs: even pin driven, odd pin released
    wr(SCC_ADDR_STATUS, 8'h30);
    for (int p = 0; p < 3; p++) begin
      wr(SCC_ADDR_CH_BASE + 8'(6 * p), 8'h2c);
      cmp("even drive", 16'h0000, {15'h0000, pin_oe_n[2 * p]});
      cmp("odd release", 16'h0001, {15'h0000, pin_oe_n[2 * p + 1]});
    end
    // pair 0 toggling: even value 2 governs until the wrap, then odd value 6
    wr(SCC_ADDR_CH_BASE, 8'h24);
    wr(8'h27, 8'h00);
    wr(8'h28, 8'h02);
    wr(8'h2a, 8'h00);
    wr(8'h2b, 8'h06);
    wr(SCC_ADDR_STATUS, 8'h17);
    env_u.pulse_ext(2);
    chk_pin(0, 1'b1);
    env_u.pulse_ext(4);
    chk_pin(0, 1'b1);
    env_u.pulse_ext(4);
    chk_pin(0, 1'b1);
    env_u.pulse_ext(4);
    chk_pin(0, 1'b0);
    test_done;
  end
endmodule // testbench
